// File: hdl/dcpr_pkg.sv
// package for the dual-channel power removal supervisor
// assumes a 20 MHz clock and a millisecond timebase derived from it
package dcpr_pkg;
   localparam int unsigned CLK_HZ = 20000000;
   localparam int unsigned TICK_MS = 1;
   localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned MIN_HOLD_MS = 15;
   localparam logic [7:0] HOLD_MS = 8'h0f;
   localparam logic [7:0] DUAL_CHECK_MIN = 8'h0b;
   localparam logic [7:0] DUAL_CHECK_MAX = 8'h64;
   localparam logic [1:0] CLR_EDGE = 2'h1;
   localparam logic [1:0] CLR_LEVEL = 2'h2;
   localparam logic [7:0] DUAL_CHECK_RST = 8'h00;
   localparam logic ALARM_ON_OFF_RST = 1'b0;
   localparam logic [1:0] CLR_MODE_RST = 2'h1;
   localparam logic [31:0] WB_ZERO = 32'h00000000;
   // register offsets, byte addresses
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'hc;
   // ctrl field positions
   localparam int CTRL_CLR_MODE_LSB = 0;
   localparam int CTRL_ALARM_ON_OFF = 2;
   localparam int CTRL_DUAL_LSB = 8;
   localparam int CTRL_BRAKE_MOTOR = 16;
   // event bit positions
   localparam int EV_ENTER = 0;
   localparam int EV_RELEASE = 1;
   localparam int EV_CLEAR = 2;
   localparam int EV_DET_ALARM = 3;
   localparam int EV_CIRC_ALARM = 4;
   localparam int EV_W = 5;
   // indicator codes
   typedef enum logic [1:0] {
      IND_WHITE_ON = 2'h0,
      IND_WHITE_BLINK = 2'h1,
      IND_RED_BLINK = 2'h2
   } dcpr_ind_t;
   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_REMOVED = 3'b010,
      ST_LATCHED = 3'b100
   } dcpr_state_t;
   typedef struct packed {
      logic [1:0] clr_mode;
      logic alarm_on_off;
      logic [7:0] dual_ms;
      logic brake_motor;
   } dcpr_cfg_t;
endpackage : dcpr_pkg

// File: hdl/dcpr_top.sv
// dual-channel power removal supervisor with a wishbone classic slave
// assumes inputs synchronous to clk_i; safety inputs high = active (on)
// assumes TICK_CYCLES clocks make one millisecond; a bench may shorten it
// Behaviour
// - channel a inactive forces all upper-arm gate drives off.
// - channel b inactive forces all lower-arm gate drives off.
// - both inputs inactive enters power removal, motor unexcited.
// - inactive pulses shorter than 15 ms may be ignored.
// - alarm setting off: stop monitor on, indicator blinks white on either off.
// - entering stop from safety inputs drops the ready output.
// - entering power removal engages the brake on brake motors.
// - removal lifts only when both inputs are active.
// - active periods shorter than 15 ms may be ignored.
// - after release motor stays unexcited until stop latch cleared.
// - clear input after release clears latch, monitor off, steady white, excite.
// - clearing the stop latch reasserts the ready output.
// - clearing the stop latch releases the brake on brake motors.
// - failure monitor on only when both inputs inactive.
// - clear mode 1 judges rising edge, 2 judges level, default 1.
// - mismatch beyond 11..100 ms threshold raises circuit error; 0..10 disables.
// - alarm setting on: both off raises detection alarm, red blink, monitor off.
//
// The placing of the registers and register access over Wishbone were chosen for this implementation.
module dcpr_top #(
   parameter int unsigned TICK_CYCLES = dcpr_pkg::TICK_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o,
   input wire logic safe_off_in_a_i,
   input wire logic safe_off_in_b_i,
   input wire logic stop_latch_clear_in_i,
   input wire logic [2:0] upper_gate_i,
   input wire logic [2:0] lower_gate_i,
   output logic [2:0] upper_gate_o,
   output logic [2:0] lower_gate_o,
   output logic excite_o,
   output logic ready_o,
   output logic brake_engage_o,
   output logic safe_fail_monitor_out_o,
   output logic stop_latch_monitor_out_o,
   output logic [1:0] status_indicator_o,
   output logic irq_o
);
   // synchroniser and filter state
   logic [1:0] sync_a_reg, sync_a_next, sync_b_reg, sync_b_next;
   logic [1:0] clr_sync_reg, clr_sync_next;
   logic clr_prev_reg, clr_prev_next;
   logic [15:0] tick_cnt_reg, tick_cnt_next;
   logic tick;
   logic both_off_reg, both_off_next, both_on_reg, both_on_next;
   logic [7:0] off_ms_reg, off_ms_next, on_ms_reg, on_ms_next;
   logic [7:0] mis_ms_reg, mis_ms_next;
   dcpr_pkg::dcpr_state_t state_reg, state_next;
   logic det_alarm_reg, det_alarm_next, circ_alarm_reg, circ_alarm_next;
   logic stop_mon_reg, stop_mon_next;
   dcpr_pkg::dcpr_cfg_t cfg_reg, cfg_next;
   logic [dcpr_pkg::EV_W-1:0] irq_stat_reg, irq_stat_next, irq_mask_reg, irq_mask_next;
   logic [dcpr_pkg::EV_W-1:0] ev;
   logic ack_reg, ack_next;
   logic [31:0] rdat_reg, rdat_next;
   logic a_on, b_on, clr_lvl, clr_hit, wr, rd;

   // saturating ms step, so a stuck input never wraps back to zero
   function automatic logic [7:0] sat_inc(input logic [7:0] v);
      sat_inc = (v == 8'hff) ? v : v + 8'h01;
   endfunction : sat_inc

   // only the second synchroniser flop is ever read
   assign a_on = sync_a_reg[1];
   assign b_on = sync_b_reg[1];
   assign clr_lvl = clr_sync_reg[1];
   assign tick = (tick_cnt_reg == 16'(TICK_CYCLES - 1));
   assign wr = wb_cyc_i && wb_stb_i && !ack_reg && wb_we_i;
   assign rd = wb_cyc_i && wb_stb_i && !ack_reg && !wb_we_i;

   // two-flop synchronisers and the millisecond timebase
   always_comb begin
      sync_a_next = {sync_a_reg[0], safe_off_in_a_i};
      sync_b_next = {sync_b_reg[0], safe_off_in_b_i};
      clr_sync_next = {clr_sync_reg[0], stop_latch_clear_in_i};
      clr_prev_next = clr_lvl;
      tick_cnt_next = tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
   end

   // qualify both-off / both-on only after the 15 ms hold; glitches are dropped
   always_comb begin
      off_ms_next = (a_on || b_on) ? 8'h00 : (tick ? sat_inc(off_ms_reg) : off_ms_reg);
      on_ms_next = (a_on && b_on) ? (tick ? sat_inc(on_ms_reg) : on_ms_reg) : 8'h00;
      both_off_next = both_off_reg;
      both_on_next = both_on_reg;
      if (a_on || b_on) begin
         both_off_next = 1'b0;
      end else if (off_ms_reg >= dcpr_pkg::HOLD_MS) begin
         both_off_next = 1'b1;
      end
      if (!(a_on && b_on)) begin
         both_on_next = 1'b0;
      end else if (on_ms_reg >= dcpr_pkg::HOLD_MS) begin
         both_on_next = 1'b1;
      end
      // mismatch timer for the dual-channel check
      mis_ms_next = (a_on != b_on) ? (tick ? sat_inc(mis_ms_reg) : mis_ms_reg) : 8'h00;
   end

   // rising edge or level, per configured clear mode
   assign clr_hit = (cfg_reg.clr_mode == dcpr_pkg::CLR_LEVEL) ? clr_lvl
                                                            : (clr_lvl && !clr_prev_reg);

   // supervisor state machine and alarms
   always_comb begin
      state_next = state_reg;
      det_alarm_next = det_alarm_reg;
      circ_alarm_next = circ_alarm_reg;
      stop_mon_next = stop_mon_reg;
      ev = '0;
      unique case (state_reg)
         dcpr_pkg::ST_RUN: begin
            if (both_off_reg) begin
               state_next = dcpr_pkg::ST_REMOVED;
               ev[dcpr_pkg::EV_ENTER] = 1'b1;
            end else if (!a_on || !b_on) begin
               state_next = dcpr_pkg::ST_LATCHED; // stop latch on single-channel off
            end
         end
         dcpr_pkg::ST_REMOVED: begin
            if (both_on_reg) begin
               state_next = dcpr_pkg::ST_LATCHED;
               ev[dcpr_pkg::EV_RELEASE] = 1'b1;
            end
         end
         dcpr_pkg::ST_LATCHED: begin
            if (both_off_reg) begin
               state_next = dcpr_pkg::ST_REMOVED;
               ev[dcpr_pkg::EV_ENTER] = 1'b1;
            end else if (a_on && b_on && clr_hit) begin
               state_next = dcpr_pkg::ST_RUN;
               ev[dcpr_pkg::EV_CLEAR] = 1'b1;
            end
         end
      endcase
      // monitor sets on either input off while alarm setting disabled and holds until the clear or until the alarm setting is enabled
      if (!cfg_reg.alarm_on_off && (!a_on || !b_on)) begin
         stop_mon_next = 1'b1;
      end else if (ev[dcpr_pkg::EV_CLEAR] || cfg_reg.alarm_on_off) begin
         stop_mon_next = 1'b0;
      end
      if (cfg_reg.alarm_on_off && ev[dcpr_pkg::EV_ENTER] && !det_alarm_reg) begin
         det_alarm_next = 1'b1;
         ev[dcpr_pkg::EV_DET_ALARM] = 1'b1;
      end
      if (cfg_reg.dual_ms >= dcpr_pkg::DUAL_CHECK_MIN && cfg_reg.dual_ms <= dcpr_pkg::DUAL_CHECK_MAX
          && mis_ms_reg > cfg_reg.dual_ms && !circ_alarm_reg) begin
         circ_alarm_next = 1'b1;
         ev[dcpr_pkg::EV_CIRC_ALARM] = 1'b1;
      end
      // alarms are sticky until cleared with the stop latch
      if (ev[dcpr_pkg::EV_CLEAR]) begin
         det_alarm_next = 1'b0;
         circ_alarm_next = 1'b0;
      end
   end

   // wishbone slave: one wait state, reads of irq status clear it (set wins)
   always_comb begin
      cfg_next = cfg_reg;
      irq_mask_next = irq_mask_reg;
      irq_stat_next = irq_stat_reg;
      ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
      rdat_next = dcpr_pkg::WB_ZERO;
      if (wr && wb_adr_i[3:0] == dcpr_pkg::ADDR_CTRL) begin
         if (wb_sel_i[0]) begin
            cfg_next.clr_mode = wb_dat_i[dcpr_pkg::CTRL_CLR_MODE_LSB +: 2];
            cfg_next.alarm_on_off = wb_dat_i[dcpr_pkg::CTRL_ALARM_ON_OFF];
         end
         if (wb_sel_i[1]) begin
            cfg_next.dual_ms = wb_dat_i[dcpr_pkg::CTRL_DUAL_LSB +: 8];
         end
         if (wb_sel_i[2]) begin
            cfg_next.brake_motor = wb_dat_i[dcpr_pkg::CTRL_BRAKE_MOTOR];
         end
      end
      if (wr && wb_adr_i[3:0] == dcpr_pkg::ADDR_IRQ_MASK && wb_sel_i[0]) begin
         irq_mask_next = wb_dat_i[dcpr_pkg::EV_W-1:0];
      end
      if (rd) begin
         unique case (wb_adr_i[3:0])
            dcpr_pkg::ADDR_CTRL: begin
               rdat_next[dcpr_pkg::CTRL_CLR_MODE_LSB +: 2] = cfg_reg.clr_mode;
               rdat_next[dcpr_pkg::CTRL_ALARM_ON_OFF] = cfg_reg.alarm_on_off;
               rdat_next[dcpr_pkg::CTRL_DUAL_LSB +: 8] = cfg_reg.dual_ms;
               rdat_next[dcpr_pkg::CTRL_BRAKE_MOTOR] = cfg_reg.brake_motor;
            end
            dcpr_pkg::ADDR_STATUS: begin
               rdat_next[7:0] = {circ_alarm_reg, det_alarm_reg, b_on, a_on,
                                 1'b0, state_reg};
            end
            dcpr_pkg::ADDR_IRQ_STAT: begin
               rdat_next[dcpr_pkg::EV_W-1:0] = irq_stat_reg;
               irq_stat_next = '0;
            end
            dcpr_pkg::ADDR_IRQ_MASK: begin
               rdat_next[dcpr_pkg::EV_W-1:0] = irq_mask_reg;
            end
            default: begin
               rdat_next = dcpr_pkg::WB_ZERO; // unmapped reads as zero
            end
         endcase
      end
      irq_stat_next = irq_stat_next | ev;
   end

   // synchroniser, clear edge detector and timebase flops
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync_a_reg <= 2'h0;
         sync_b_reg <= 2'h0;
         clr_sync_reg <= 2'h0;
         clr_prev_reg <= 1'b0;
         tick_cnt_reg <= 16'h0000;
      end else begin
         sync_a_reg <= sync_a_next;
         sync_b_reg <= sync_b_next;
         clr_sync_reg <= clr_sync_next;
         clr_prev_reg <= clr_prev_next;
         tick_cnt_reg <= tick_cnt_next;
      end
   end

   // hold filters and mismatch timer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         both_off_reg <= 1'b0;
         both_on_reg <= 1'b0;
         off_ms_reg <= 8'h00;
         on_ms_reg <= 8'h00;
         mis_ms_reg <= 8'h00;
      end else begin
         both_off_reg <= both_off_next;
         both_on_reg <= both_on_next;
         off_ms_reg <= off_ms_next;
         on_ms_reg <= on_ms_next;
         mis_ms_reg <= mis_ms_next;
      end
   end

   // supervisor state; reset lands in latched so a clear is needed to run
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= dcpr_pkg::ST_LATCHED;
         det_alarm_reg <= 1'b0;
         circ_alarm_reg <= 1'b0;
         stop_mon_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         det_alarm_reg <= det_alarm_next;
         circ_alarm_reg <= circ_alarm_next;
         stop_mon_reg <= stop_mon_next;
      end
   end

   // bus-visible configuration, interrupt and answer flops
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_reg <= '{clr_mode: dcpr_pkg::CLR_MODE_RST, alarm_on_off: dcpr_pkg::ALARM_ON_OFF_RST,
                      dual_ms: dcpr_pkg::DUAL_CHECK_RST, brake_motor: 1'b0};
         irq_stat_reg <= '0;
         irq_mask_reg <= '0;
         ack_reg <= 1'b0;
         rdat_reg <= dcpr_pkg::WB_ZERO;
      end else begin
         cfg_reg <= cfg_next;
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
         ack_reg <= ack_next;
         rdat_reg <= rdat_next;
      end
   end

   // gate cut is combinational from the synchronised inputs so it never waits on the fsm
   assign upper_gate_o = a_on ? upper_gate_i : 3'h0;
   assign lower_gate_o = b_on ? lower_gate_i : 3'h0;
   assign excite_o = (state_reg == dcpr_pkg::ST_RUN);
   assign ready_o = (state_reg == dcpr_pkg::ST_RUN);
   // brake engages whenever unexcited on a brake motor
   assign brake_engage_o = cfg_reg.brake_motor && (state_reg != dcpr_pkg::ST_RUN);
   // failure monitor follows the synced pins, not the filtered state
   assign safe_fail_monitor_out_o = !a_on && !b_on;
   assign stop_latch_monitor_out_o = stop_mon_reg;
   assign status_indicator_o = (det_alarm_reg || circ_alarm_reg) ? dcpr_pkg::IND_RED_BLINK
                             : stop_mon_reg ? dcpr_pkg::IND_WHITE_BLINK : dcpr_pkg::IND_WHITE_ON;
   // level interrupt from sticky status and mask
   assign irq_o = |(irq_stat_reg & irq_mask_reg);
   // bus answers come straight from flops
   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdat_reg;
endmodule : dcpr_top

// File: testbench/dcpr_checker.sv
// checker: concurrent properties on the supervisor top-level ports
// assumes sync active-high reset and two-flop input synchronisers
module dcpr_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic safe_off_in_a_i,
   input wire logic safe_off_in_b_i,
   input wire logic [2:0] upper_gate_i,
   input wire logic [2:0] upper_gate_o,
   input wire logic [2:0] lower_gate_o,
   input wire logic excite_o,
   input wire logic ready_o,
   input wire logic brake_engage_o,
   input wire logic safe_fail_monitor_out_o,
   input wire logic stop_latch_monitor_out_o,
   input wire logic [1:0] status_indicator_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // three samples cover the synchroniser lag
   a_upper_off: assert property (!safe_off_in_a_i [*3] |-> upper_gate_o == 3'h0)
      else $error("upper gates not forced off");
   a_upper_pass: assert property (safe_off_in_a_i [*3] |-> upper_gate_o == upper_gate_i)
      else $error("upper gates not passed");
   a_lower_off: assert property (!safe_off_in_b_i [*3] |-> lower_gate_o == 3'h0)
      else $error("lower gates not forced off");
   a_fail_both: assert property ((!safe_off_in_a_i && !safe_off_in_b_i) [*3]
      |-> safe_fail_monitor_out_o) else $error("fail monitor missing");
   a_fail_not_both: assert property ((safe_off_in_a_i || safe_off_in_b_i) [*3]
      |-> !safe_fail_monitor_out_o) else $error("fail monitor spurious");
   a_run_needs_both: assert property ((!safe_off_in_a_i || !safe_off_in_b_i) [*5]
      |-> !excite_o) else $error("excited with a channel off");
   a_ready_brake: assert property (ready_o |-> !brake_engage_o)
      else $error("brake held while ready");
   a_excite_rise: assert property ($rose(excite_o) |->
      safe_off_in_a_i && safe_off_in_b_i ##[0:2] !stop_latch_monitor_out_o)
      else $error("bad excite rise");
   a_ready_white: assert property (ready_o |-> status_indicator_o == 2'h0)
      else $error("indicator not steady white");
   a_ack_once: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack timing wrong");
   c_excite: cover property ($rose(excite_o));
   c_fail: cover property ($rose(safe_fail_monitor_out_o));
   c_brake: cover property ($rose(brake_engage_o));
endmodule : dcpr_checker

bind dcpr_top dcpr_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
   .safe_off_in_a_i, .safe_off_in_b_i, .upper_gate_i, .upper_gate_o, .lower_gate_o,
   .excite_o, .ready_o, .brake_engage_o, .safe_fail_monitor_out_o,
   .stop_latch_monitor_out_o, .status_indicator_o);

// File: testbench/dcpr_safety_partner.sv
// partner: safety contacts and the stop-latch clear switch
// assumes the bench calls its tasks; signals change just after edges
module dcpr_safety_partner #(
   parameter int unsigned TICK = dcpr_pkg::TICK_CYCLES
) (
   input wire logic clk_i,
   output logic safe_a_o,
   output logic safe_b_o,
   output logic clear_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // contacts open at power-up, like a tripped relay
   initial begin
      safe_a_o = 1'b0;
      safe_b_o = 1'b0;
      clear_o = 1'b0;
   end
   // each state is held for ms milliseconds of TICK clocks
   task automatic drive(input logic a, input logic b, input int ms);
      @(posedge clk_i);
      safe_a_o <= a;
      safe_b_o <= b;
      repeat (ms * int'(TICK)) @(posedge clk_i);
   endtask : drive
   task automatic clear_pulse(input int n);
      @(posedge clk_i);
      clear_o <= 1'b1;
      repeat (n) @(posedge clk_i);
      clear_o <= 1'b0;
      repeat (n) @(posedge clk_i);
   endtask : clear_pulse
endmodule : dcpr_safety_partner

// File: testbench/testbench.sv
// testbench: removal, release and clear of the supervisor against a model
// assumes the partner module plays the contacts; wishbone single cycles
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [31:0] adr = 32'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic [31:0] q;
   logic we = 1'b0;
   logic cyc = 1'b0;
   logic [2:0] ug = 3'h0;
   logic [2:0] lg = 3'h0;
   logic [2:0] ug_o, lg_o;
   logic sa, sb, sclr, ack, exc, rdy, brk, fmon, smon, irq;
   logic [1:0] ind;
   logic brake = 1'b0;
   int err_count = 0;
   int checks = 0;
   int cyc_cnt = 0;
   int st = 4; // model state: 1 run, 2 removed, 4 latched
   // one ms shortened to 20 clocks so the 15 ms holds fit a short run
   localparam int unsigned SIM_TICK = 20;
   always #25 clk_i = ~clk_i;
   dcpr_safety_partner #(.TICK(SIM_TICK)) u_part (.clk_i, .safe_a_o(sa), .safe_b_o(sb),
      .clear_o(sclr));
   dcpr_top #(.TICK_CYCLES(SIM_TICK)) DUT (.clk_i, .rst_i, .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_dat_o(rdat),
      .wb_we_i(we), .wb_sel_i(4'hf), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_ack_o(ack),
      .safe_off_in_a_i(sa), .safe_off_in_b_i(sb), .stop_latch_clear_in_i(sclr),
      .upper_gate_i(ug), .lower_gate_i(lg), .upper_gate_o(ug_o), .lower_gate_o(lg_o),
      .excite_o(exc), .ready_o(rdy), .brake_engage_o(brk), .safe_fail_monitor_out_o(fmon),
      .stop_latch_monitor_out_o(smon), .status_indicator_o(ind), .irq_o(irq));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // one classic cycle; stb shares cyc since both rise and fall together
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      we <= w;
      adr <= {28'h0, a};
      wdat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 100);
      if (n >= 100) err_count++;
      q = rdat;
      cyc <= 1'b0;
   endtask : bus
   task automatic check_all();
      @(negedge clk_i);
      chk(ug_o, sa ? ug : 3'h0);
      chk(lg_o, sb ? lg : 3'h0);
      chk({rdy, exc}, (st == 1) ? 2'h3 : 2'h0);
      chk(brk, brake && st != 1);
      chk(fmon, !sa && !sb);
      bus(1'b0, dcpr_pkg::ADDR_STATUS, 32'h0);
      chk(q[2:0], st[2:0]);
   endtask : check_all
   task automatic conclude();
      $display("checks=%0d errors=%0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : conclude
   // fresh gate requests every cycle exercise the pass-through path
   initial begin
      void'($urandom(69098));
      forever begin
         @(posedge clk_i);
         ug <= 3'($urandom());
         lg <= 3'($urandom());
      end
   end
   always @(posedge clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 10000) begin
         err_count++;
         conclude();
      end
   end
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      check_all();
      bus(1'b0, dcpr_pkg::ADDR_CTRL, 32'h0);
      chk(q, 32'h1);
      bus(1'b0, 4'h2, 32'h0);
      chk(q, 32'h0); // unmapped offset reads zero
      bus(1'b1, dcpr_pkg::ADDR_CTRL, 32'h00010001);
      brake = 1'b1;
      u_part.drive(1'b1, 1'b1, 17);
      check_all();
      u_part.clear_pulse(4);
      st = 1;
      check_all();
      chk({smon, ind, irq}, 4'h0);
      bus(1'b1, dcpr_pkg::ADDR_IRQ_MASK, 32'h1f);
      @(negedge clk_i);
      chk(irq, 1'b1); // pending clear event now unmasked
      bus(1'b0, dcpr_pkg::ADDR_IRQ_STAT, 32'h0);
      chk(q[dcpr_pkg::EV_CLEAR], 1'b1);
      bus(1'b0, dcpr_pkg::ADDR_IRQ_STAT, 32'h0);
      @(negedge clk_i);
      chk(q, 32'h0); // status cleared by the read
      chk(irq, 1'b0); // nothing pending after the read
      st = 4;
      u_part.drive(1'b0, 1'b1, 1);
      check_all();
      chk({smon, ind}, 3'h5);
      u_part.drive(1'b0, 1'b0, 17);
      st = 2;
      check_all();
      u_part.drive(1'b1, 1'b0, 17);
      check_all();
      u_part.drive(1'b1, 1'b1, 17);
      st = 4;
      check_all();
      bus(1'b1, dcpr_pkg::ADDR_CTRL, 32'h00010002);
      u_part.clear_pulse(4);
      st = 1;
      check_all();
      // alarm setting on, dual check at 11 ms, edge clear
      bus(1'b1, dcpr_pkg::ADDR_CTRL, 32'h00010b05);
      u_part.drive(1'b0, 1'b1, 17);
      st = 4;
      check_all();
      chk(q[7:4], 4'ha);
      chk({smon, ind}, 3'h2);
      u_part.drive(1'b0, 1'b0, 17);
      st = 2;
      check_all();
      chk(q[7:4], 4'hc);
      chk({smon, ind}, 3'h2);
      u_part.drive(1'b1, 1'b1, 17);
      u_part.clear_pulse(4);
      st = 1;
      check_all();
      chk({q[7:4], smon, ind}, 7'h18);
      conclude();
   end
endmodule : testbench
